// File: hw/pixel_corr_pkg.sv
package pixel_corr_pkg;

	// ****************************************
	// widths
	// ****************************************
	localparam int PIX_W = 10;
	localparam int OFF_W = 8;
	localparam int ADDR_W = 5;
	localparam int REG_W = 8;
	localparam int PROD_W = 20;
	localparam int FIFO_DEPTH = 16;
	localparam int SYNC_W = 15;

	// ****************************************
	// configuration register addresses
	// ****************************************
	localparam logic [ADDR_W-1:0] REG_FIXED_OFFSET = 5'h06;
	localparam logic [ADDR_W-1:0] REG_FIXED_GAIN_A = 5'h07;
	localparam logic [ADDR_W-1:0] REG_FIXED_GAIN_B = 5'h08;
	localparam logic [ADDR_W-1:0] REG_CORR_CTRL = 5'h09;
	localparam logic [ADDR_W-1:0] REG_BUS_CFG = 5'h19;

	// ****************************************
	// field positions
	// ****************************************
	localparam int CTRL_OFFSET_FIXED_BIT = 0;
	localparam int CTRL_GAIN_FIXED_BIT = 1;
	localparam int CTRL_RANGE_LO_BIT = 2;
	localparam int CTRL_RANGE_HI_BIT = 3;
	localparam int BUS_CFG_NARROW_BIT = 6;
	localparam int GAIN_B_USED_BITS = 2;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [REG_W-1:0] FIXED_OFFSET_RST = 8'h00;
	localparam logic [REG_W-1:0] FIXED_GAIN_A_RST = 8'h00;
	localparam logic [REG_W-1:0] FIXED_GAIN_B_RST = 8'h00;
	localparam logic [REG_W-1:0] CORR_CTRL_RST = 8'h00;
	localparam logic [REG_W-1:0] BUS_CFG_RST = 8'h00;

	// ****************************************
	// gain divisor shifts (log2 of N)
	// ****************************************
	localparam logic [4:0] SHIFT_W10_R15 = 5'h0b;
	localparam logic [4:0] SHIFT_W10_R20 = 5'h0a;
	localparam logic [4:0] SHIFT_W10_R30 = 5'h09;
	localparam logic [4:0] SHIFT_W8_R15 = 5'h09;
	localparam logic [4:0] SHIFT_W8_R20 = 5'h08;
	localparam logic [4:0] SHIFT_W8_R30 = 5'h07;
	localparam logic [PIX_W-1:0] PIX_MAX = 10'h3ff;

	typedef enum logic [1:0] {RANGE_1P5, RANGE_2P0, RANGE_3P0} gain_range_e;

	// range bits {hi,lo}: 1,0 -> 1:1.5, 0,1 -> 1:2, 0,0 -> 1:3; 1,1 taken as 1:3
	function automatic gain_range_e decode_range(input logic [1:0] bits);
		case (bits)
			2'h2: decode_range = RANGE_1P5;
			2'h1: decode_range = RANGE_2P0;
			default: decode_range = RANGE_3P0;
		endcase
	endfunction : decode_range

endpackage : pixel_corr_pkg

// File: hw/corr_fifo.sv
`timescale 1ns/1ps
module corr_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;
	logic push;
	logic pop;

	assign in_ready = (count_q != DEPTH[AW:0]);
	assign out_valid = (count_q != '0);
	assign out_data = mem_q[rd_ptr_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk)
	begin
		if (push)
		begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	// pointers wrap naturally only for power-of-two depths
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop)
			begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			count_q <= '0;
		end
		else if (push && !pop)
		begin
			count_q <= count_q + 1'b1;
		end
		else if (pop && !push)
		begin
			count_q <= count_q - 1'b1;
		end
	end

endmodule : corr_fifo

// File: hw/shading_mult.sv
`timescale 1ns/1ps
module shading_mult
	import pixel_corr_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic [PIX_W-1:0] pixel,
	input wire logic [PIX_W-1:0] coef,
	input wire logic narrow,
	input wire logic [1:0] range_bits,
	output logic [PIX_W-1:0] result_q
);
	logic [PIX_W-1:0] coef_eff;
	logic [PROD_W-1:0] product;
	logic [4:0] shift;
	logic [PROD_W-1:0] scaled;
	logic [PROD_W:0] total;
	gain_range_e range;

	assign range = decode_range(range_bits);
	// narrow bus: only the low byte carries the coefficient
	assign coef_eff = narrow ? {2'h0, coef[OFF_W-1:0]} : coef;
	assign product = pixel * coef_eff;

	always_comb
	begin
		shift = SHIFT_W10_R30;
		case (range)
			RANGE_1P5: shift = narrow ? SHIFT_W8_R15 : SHIFT_W10_R15;
			RANGE_2P0: shift = narrow ? SHIFT_W8_R20 : SHIFT_W10_R20;
			RANGE_3P0: shift = narrow ? SHIFT_W8_R30 : SHIFT_W10_R30;
			default: shift = SHIFT_W10_R30;
		endcase
	end

	// gain = 1 + coef/N, so result = pixel + pixel*coef/N
	assign scaled = product >> shift;
	assign total = {{(PROD_W+1-PIX_W){1'b0}}, pixel} + {1'b0, scaled};

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			result_q <= '0;
		end
		else if (en)
		begin
			result_q <= (total > {{(PROD_W+1-PIX_W){1'b0}}, PIX_MAX}) ? PIX_MAX : total[PIX_W-1:0];
		end
	end

endmodule : shading_mult

// File: hw/pixel_rate_correction_path.sv
// How it works
// - converter feeds 10-bit codes, one per pixel
// - offset subtraction comes before gain correction
// - control bit 0 low: bus offset per pixel
// - control bit 0 high: fixed offset register used
// - offset output is code minus offset, floored at zero
// - bus offset uses low byte, upper ignored
// - offset result feeds the shading multiplier
// - control bit 1 low: bus gain per pixel
// - control bit 1 high: fixed gain registers used
// - gain stage is 10x10 multiplier per pixel
// - gain is one plus coefficient over N
// - narrow bus uses low byte, smaller N
// - corrected pixel appears on output bus
`timescale 1ns/1ps
module pixel_rate_correction_path
	import pixel_corr_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [PIX_W-1:0] adc_code,
	input wire logic adc_valid,
	output logic adc_ready,
	input wire logic [PIX_W-1:0] correction_coefficient_bus,
	input wire logic cs_n_pin,
	input wire logic wr_n_pin,
	input wire logic rd_n_pin,
	input wire logic rd_pixel_n_pin,
	input wire logic sync_pin,
	input wire logic [PIX_W-1:0] pixel_output_bus_in,
	output logic [PIX_W-1:0] pixel_output_bus,
	output logic pixel_output_bus_oe
);

	// ****************************************
	// pin synchronisers
	// ****************************************
	// bit order: data bus, sync, rd_pixel_n, rd_n, wr_n, cs_n
	localparam int P_CS = 0;
	localparam int P_WR = 1;
	localparam int P_RD = 2;
	localparam int P_RDPIX = 3;
	localparam int P_SYNC = 4;
	localparam int P_DATA = 5;

	logic [SYNC_W-1:0] pins_raw;
	logic [SYNC_W-1:0] meta_q;
	logic [SYNC_W-1:0] stage2_q;
	logic [SYNC_W-1:0] stage3_q;
	logic [SYNC_W-1:0] filt_q;
	logic [SYNC_W-1:0] filt_prev_q;
	logic [PIX_W-1:0] coef_meta_q;
	logic [PIX_W-1:0] coef_s2_q;
	logic [PIX_W-1:0] coef_s3_q;
	logic [PIX_W-1:0] coef_filt_q;

	assign pins_raw = {pixel_output_bus_in, sync_pin, rd_pixel_n_pin, rd_n_pin, wr_n_pin, cs_n_pin};

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			meta_q <= 15'h000f;
			stage2_q <= 15'h000f;
			stage3_q <= 15'h000f;
			coef_meta_q <= '0;
			coef_s2_q <= '0;
			coef_s3_q <= '0;
		end
		else
		begin
			meta_q <= pins_raw;
			stage2_q <= meta_q;
			stage3_q <= stage2_q;
			coef_meta_q <= correction_coefficient_bus;
			coef_s2_q <= coef_meta_q;
			coef_s3_q <= coef_s2_q;
		end
	end

	// a bit is accepted only once the last two stages agree
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++)
		begin : g_pin_filt
			always_ff @(posedge clk)
			begin
				if (!rst_n)
				begin
					filt_q[gi] <= (gi < P_SYNC) ? 1'b1 : 1'b0;
				end
				else if (stage2_q[gi] == stage3_q[gi])
				begin
					filt_q[gi] <= stage3_q[gi];
				end
			end
		end
		for (gi = 0; gi < PIX_W; gi++)
		begin : g_coef_filt
			always_ff @(posedge clk)
			begin
				if (!rst_n)
				begin
					coef_filt_q[gi] <= 1'b0;
				end
				else if (coef_s2_q[gi] == coef_s3_q[gi])
				begin
					coef_filt_q[gi] <= coef_s3_q[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			filt_prev_q <= 15'h000f;
		end
		else
		begin
			filt_prev_q <= filt_q;
		end
	end

	logic cs_active;
	logic wr_done;
	logic rd_start;
	logic rd_end;
	logic rdpix_start;
	logic rdpix_end;
	logic sync_high;
	logic [PIX_W-1:0] bus_word;

	assign cs_active = !filt_q[P_CS];
	assign wr_done = filt_q[P_WR] && !filt_prev_q[P_WR];
	assign rd_start = !filt_q[P_RD] && filt_prev_q[P_RD];
	assign rd_end = filt_q[P_RD] && !filt_prev_q[P_RD];
	assign rdpix_start = !filt_q[P_RDPIX] && filt_prev_q[P_RDPIX];
	assign rdpix_end = filt_q[P_RDPIX] && !filt_prev_q[P_RDPIX];
	assign sync_high = filt_q[P_SYNC];
	assign bus_word = filt_q[P_DATA +: PIX_W];

	// ****************************************
	// configuration registers
	// ****************************************
	logic addr_phase_q;
	logic [ADDR_W-1:0] addr_q;
	logic [REG_W-1:0] fixed_offset_value_q;
	logic [REG_W-1:0] fixed_gain_part_a_q;
	logic [REG_W-1:0] fixed_gain_part_b_q;
	logic [REG_W-1:0] correction_control_q;
	logic [REG_W-1:0] bus_config_q;
	logic cfg_write;

	// first write byte is the address, second the data
	assign cfg_write = wr_done && cs_active && addr_phase_q;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			addr_phase_q <= 1'b0;
			addr_q <= '0;
		end
		else if (wr_done && cs_active)
		begin
			addr_phase_q <= !addr_phase_q;
			if (!addr_phase_q)
			begin
				addr_q <= bus_word[ADDR_W-1:0];
			end
		end
		else if (rd_end && cs_active)
		begin
			addr_phase_q <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			fixed_offset_value_q <= FIXED_OFFSET_RST;
			fixed_gain_part_a_q <= FIXED_GAIN_A_RST;
			fixed_gain_part_b_q <= FIXED_GAIN_B_RST;
			correction_control_q <= CORR_CTRL_RST;
			bus_config_q <= BUS_CFG_RST;
		end
		else if (cfg_write)
		begin
			case (addr_q)
				REG_FIXED_OFFSET: fixed_offset_value_q <= bus_word[REG_W-1:0];
				REG_FIXED_GAIN_A: fixed_gain_part_a_q <= bus_word[REG_W-1:0];
				REG_FIXED_GAIN_B: fixed_gain_part_b_q <= bus_word[REG_W-1:0];
				REG_CORR_CTRL: correction_control_q <= bus_word[REG_W-1:0];
				REG_BUS_CFG: bus_config_q <= bus_word[REG_W-1:0];
				default: ;
			endcase
		end
	end

	logic [REG_W-1:0] reg_read;

	always_comb
	begin
		case (addr_q)
			REG_FIXED_OFFSET: reg_read = fixed_offset_value_q;
			REG_FIXED_GAIN_A: reg_read = fixed_gain_part_a_q;
			REG_FIXED_GAIN_B: reg_read = fixed_gain_part_b_q;
			REG_CORR_CTRL: reg_read = correction_control_q;
			REG_BUS_CFG: reg_read = bus_config_q;
			default: reg_read = 8'h00;
		endcase
	end

	logic offset_fixed;
	logic gain_fixed;
	logic narrow_bus;
	logic [1:0] range_bits;
	logic [PIX_W-1:0] fixed_gain;

	assign offset_fixed = correction_control_q[CTRL_OFFSET_FIXED_BIT];
	assign gain_fixed = correction_control_q[CTRL_GAIN_FIXED_BIT];
	assign narrow_bus = bus_config_q[BUS_CFG_NARROW_BIT];
	assign range_bits = {correction_control_q[CTRL_RANGE_HI_BIT], correction_control_q[CTRL_RANGE_LO_BIT]};
	assign fixed_gain = {fixed_gain_part_b_q[GAIN_B_USED_BITS-1:0], fixed_gain_part_a_q};

	// ****************************************
	// offset subtractor stage
	// ****************************************
	logic s1_valid_q;
	logic [PIX_W-1:0] s1_pixel_q;
	logic [PIX_W-1:0] s1_gain_coef_q;
	logic s2_valid_q;
	logic fifo_in_ready;
	logic s2_advance;
	logic s1_advance;
	logic [OFF_W-1:0] offset_sel;
	logic [PIX_W:0] offset_diff;

	// stall propagates back to the converter when the fifo fills
	assign s2_advance = !s2_valid_q || fifo_in_ready;
	assign s1_advance = !s1_valid_q || s2_advance;
	assign adc_ready = s1_advance;

	// the bus offset is a byte; the two upper lines never reach it
	assign offset_sel = offset_fixed ? fixed_offset_value_q : coef_filt_q[OFF_W-1:0];
	assign offset_diff = {1'b0, adc_code} - {3'h0, offset_sel};

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s1_valid_q <= 1'b0;
			s1_pixel_q <= '0;
			s1_gain_coef_q <= '0;
		end
		else if (s1_advance)
		begin
			s1_valid_q <= adc_valid;
			if (adc_valid)
			begin
				s1_pixel_q <= offset_diff[PIX_W] ? '0 : offset_diff[PIX_W-1:0];
				// gain coefficient is captured with its own pixel
				s1_gain_coef_q <= gain_fixed ? fixed_gain : coef_filt_q;
			end
		end
	end

	// ****************************************
	// shading multiplier stage
	// ****************************************
	logic [PIX_W-1:0] s2_result;

	shading_mult u_mult (
		.clk(clk),
		.rst_n(rst_n),
		.en(s2_advance && s1_valid_q),
		.pixel(s1_pixel_q),
		.coef(s1_gain_coef_q),
		.narrow(narrow_bus),
		.range_bits(range_bits),
		.result_q(s2_result)
	);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s2_valid_q <= 1'b0;
		end
		else if (s2_advance)
		begin
			s2_valid_q <= s1_valid_q;
		end
	end

	// ****************************************
	// output buffer and pixel bus
	// ****************************************
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [PIX_W-1:0] fifo_out_data;
	logic pix_loaded_q;
	logic [PIX_W-1:0] bus_data_q;

	corr_fifo #(
		.WIDTH(PIX_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(s2_valid_q),
		.in_ready(fifo_in_ready),
		.in_data(s2_result),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// a pixel leaves the buffer only when its read strobe ends
	assign fifo_out_ready = rdpix_end && pix_loaded_q;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pix_loaded_q <= 1'b0;
		end
		else if (rdpix_start && sync_high && fifo_out_valid)
		begin
			pix_loaded_q <= 1'b1;
		end
		else if (rdpix_end)
		begin
			pix_loaded_q <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			bus_data_q <= '0;
		end
		else if (rd_start && cs_active && !sync_high)
		begin
			bus_data_q <= {2'h0, reg_read};
		end
		else if (rdpix_start && sync_high && fifo_out_valid)
		begin
			bus_data_q <= fifo_out_data;
		end
	end

	assign pixel_output_bus = bus_data_q;
	// rd low drives the bus even without chip select
	assign pixel_output_bus_oe = !filt_q[P_RD] || (sync_high && !filt_q[P_RDPIX]);

endmodule : pixel_rate_correction_path

// File: verif/pixel_corr_properties.sv
`timescale 1ns/1ps
module pixel_corr_properties
	import pixel_corr_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic adc_ready,
	input wire logic rd_n_pin,
	input wire logic rd_pixel_n_pin,
	input wire logic sync_pin,
	input wire logic [PIX_W-1:0] pixel_output_bus,
	input wire logic pixel_output_bus_oe
);
	// ****
	// pin and flow checks
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_reg_read_drive: assert property ((!rd_n_pin)[*8] |-> pixel_output_bus_oe)
		else $error("bus idle during register read");
	a_pix_read_drive: assert property ((sync_pin && !rd_pixel_n_pin)[*8] |-> pixel_output_bus_oe)
		else $error("bus idle during pixel read");
	a_idle_release: assert property ((rd_n_pin && (rd_pixel_n_pin || !sync_pin))[*8] |-> !pixel_output_bus_oe)
		else $error("bus driven while idle");
	a_sync_delay: assert property ($fell(rd_n_pin) && !pixel_output_bus_oe |=> !pixel_output_bus_oe)
		else $error("bus driven before pin synced");
	a_bus_holds: assert property ((rd_n_pin && rd_pixel_n_pin)[*8] |=> $stable(pixel_output_bus))
		else $error("output changed without a read");
	a_full_holds: assert property (rd_pixel_n_pin[*8] ##0 !adc_ready |=> !adc_ready)
		else $error("ready rose without a pop");
	a_pop_frees: assert property (!adc_ready && $rose(rd_pixel_n_pin) && sync_pin |-> ##[1:12] adc_ready)
		else $error("ready stuck after pop");
	// reset has to be observed, so this one is not disabled by it
	a_reset_quiet: assert property (disable iff (1'b0)
		!rst_n |=> !pixel_output_bus_oe && pixel_output_bus == 10'h000)
		else $error("bus not quiet in reset");

	c_full: cover property (!adc_ready);
	c_pix_read: cover property (sync_pin && !rd_pixel_n_pin && pixel_output_bus_oe);
	c_reg_read: cover property (!rd_n_pin && pixel_output_bus_oe);
endmodule : pixel_corr_properties

bind pixel_rate_correction_path pixel_corr_properties u_pixel_corr_properties (.clk(clk), .rst_n(rst_n),
	.adc_ready(adc_ready), .rd_n_pin(rd_n_pin), .rd_pixel_n_pin(rd_pixel_n_pin), .sync_pin(sync_pin),
	.pixel_output_bus(pixel_output_bus), .pixel_output_bus_oe(pixel_output_bus_oe));

// File: verif/scan_ctrl_model.sv
`timescale 1ns/1ps
module scan_ctrl_model
	import pixel_corr_pkg::*;
(
	input wire logic clk,
	input wire logic [PIX_W-1:0] bus_level,
	output logic [PIX_W-1:0] coef,
	output logic cs_n,
	output logic wr_n,
	output logic rd_n,
	output logic rd_pixel_n,
	output logic sync,
	output logic [PIX_W-1:0] d_out,
	output logic d_en
);
	// ****
	// controller pin sequences, all launched after a falling edge
	// ****
	initial
	begin
		{cs_n, wr_n, rd_n, rd_pixel_n} = 4'hf;
		{sync, d_en} = 2'h0;
		d_out = 10'h000;
		coef = 10'h000;
	end

	task automatic hold(input int n);
		repeat (n) @(negedge clk);
	endtask : hold

	// data stays on the bus until the wr_n rise has passed the synchronisers
	task automatic put_byte(input logic [REG_W-1:0] b);
		d_out = {2'h0, b};
		d_en = 1'b1;
		wr_n = 1'b0;
		hold(6);
		wr_n = 1'b1;
		hold(6);
		d_en = 1'b0;
		hold(1);
	endtask : put_byte

	task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] v);
		cs_n = 1'b0;
		put_byte({3'h0, a});
		put_byte(v);
		cs_n = 1'b1;
		hold(4);
	endtask : write_reg

	task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [REG_W-1:0] v);
		cs_n = 1'b0;
		put_byte({3'h0, a});
		rd_n = 1'b0;
		hold(10);
		v = bus_level[REG_W-1:0];
		rd_n = 1'b1;
		hold(6);
		cs_n = 1'b1;
		hold(4);
	endtask : read_reg

	task automatic read_pixel(output logic [PIX_W-1:0] v);
		sync = 1'b1;
		hold(4);
		rd_pixel_n = 1'b0;
		hold(8);
		v = bus_level;
		rd_pixel_n = 1'b1;
		hold(8);
		sync = 1'b0;
		hold(4);
	endtask : read_pixel

	task automatic set_coef(input logic [PIX_W-1:0] c);
		coef = c;
	endtask : set_coef
endmodule : scan_ctrl_model

// File: verif/pixel_rate_correction_path_bench.sv
`timescale 1ns/1ps
module pixel_rate_correction_path_bench
	import pixel_corr_pkg::*;
;
	// ****
	// harness
	// ****
	logic clk = 1'b0;
	logic rst_n, adc_valid, adc_ready, cs_n, wr_n, rd_n, rd_pixel_n, sync, d_en, oe;
	logic float_q = 1'b0;
	logic [PIX_W-1:0] adc_code, coef, d_out, bus_in, pix_out;
	logic [REG_W-1:0] rf [32] = '{default: 8'h00};
	logic [PIX_W-1:0] expq [$];
	int err_total = 0;
	int comparisons = 0;
	int cycles = 0;

	always #2.5 clk = ~clk;
	// a released bus toggles so a stale value can never pass for data
	always @(posedge clk) float_q <= ~float_q;
	assign bus_in = oe ? pix_out : d_en ? d_out : {5{float_q, ~float_q}};

	pixel_rate_correction_path u_pixel_rate_correction_path (.clk(clk), .rst_n(rst_n), .adc_code(adc_code),
		.adc_valid(adc_valid), .adc_ready(adc_ready), .correction_coefficient_bus(coef), .cs_n_pin(cs_n),
		.wr_n_pin(wr_n), .rd_n_pin(rd_n), .rd_pixel_n_pin(rd_pixel_n), .sync_pin(sync),
		.pixel_output_bus_in(bus_in), .pixel_output_bus(pix_out), .pixel_output_bus_oe(oe));
	scan_ctrl_model u_scan_ctrl_model (.clk(clk), .bus_level(bus_in), .coef(coef), .cs_n(cs_n), .wr_n(wr_n),
		.rd_n(rd_n), .rd_pixel_n(rd_pixel_n), .sync(sync), .d_out(d_out), .d_en(d_en));

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			err_total++;
			report_and_stop();
		end
	end

	task automatic check(input logic [PIX_W-1:0] seen, input logic [PIX_W-1:0] want, input string what);
		comparisons++;
		if (seen !== want)
		begin
			err_total++;
			$display("wrong value at %0t: %s got %h want %h", $time, what, seen, want);
		end
	endtask : check

	function automatic logic [PIX_W-1:0] model(input logic [PIX_W-1:0] code, input logic [PIX_W-1:0] cf);
		logic [PIX_W-1:0] off, c, x;
		logic [PROD_W-1:0] y;
		int sh;
		off = rf[9][0] ? {2'h0, rf[6]} : {2'h0, cf[7:0]};
		x = code > off ? code - off : 10'h000;
		c = rf[9][1] ? {rf[8][1:0], rf[7]} : cf;
		sh = rf[9][3:2] == 2'h2 ? 11 : rf[9][3:2] == 2'h1 ? 10 : 9;
		c = rf[25][6] ? {2'h0, c[7:0]} : c;
		sh = rf[25][6] ? sh - 2 : sh;
		y = x + ((x * c) >> sh);
		model = y > 1023 ? PIX_MAX : y[PIX_W-1:0];
	endfunction : model

	task automatic cfg(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] v);
		u_scan_ctrl_model.write_reg(a, v);
		if (a inside {REG_FIXED_OFFSET, REG_FIXED_GAIN_A, REG_FIXED_GAIN_B, REG_CORR_CTRL, REG_BUS_CFG})
			rf[a] = v;
	endtask : cfg

	task automatic send(input logic [PIX_W-1:0] code, input logic [PIX_W-1:0] cf, output bit took);
		int n;
		u_scan_ctrl_model.set_coef(cf);
		repeat (5) @(negedge clk);
		adc_code = code;
		adc_valid = 1'b1;
		took = 1'b0;
		// ready is read settled, well before the edge that takes the code
		for (n = 0; n < 8 && !took; n++)
		begin
			#1;
			took = adc_ready;
			@(negedge clk);
		end
		adc_valid = 1'b0;
		if (took)
			expq.push_back(model(code, cf));
	endtask : send

	task automatic px(input logic [PIX_W-1:0] code, input logic [PIX_W-1:0] cf);
		bit took;
		send(code, cf, took);
		check({9'h0, took}, 10'h001, "pixel taken");
	endtask : px

	task automatic drain();
		logic [PIX_W-1:0] v;
		while (expq.size() > 0)
		begin
			u_scan_ctrl_model.read_pixel(v);
			check(v, expq.pop_front(), "corrected pixel");
		end
	endtask : drain

	// ****
	// scenarios
	// ****
	task automatic t_regs();
		logic [REG_W-1:0] v;
		logic [ADDR_W-1:0] a [6] = '{REG_FIXED_OFFSET, REG_FIXED_GAIN_A, REG_FIXED_GAIN_B, REG_CORR_CTRL,
			REG_BUS_CFG, 5'h05};
		for (int i = 0; i < 6; i++)
		begin
			u_scan_ctrl_model.read_reg(a[i], v);
			check({2'h0, v}, {2'h0, rf[a[i]]}, "register reset");
			cfg(a[i], 8'h31 + 8'(i));
			u_scan_ctrl_model.read_reg(a[i], v);
			check({2'h0, v}, {2'h0, rf[a[i]]}, "register readback");
		end
		cfg(REG_BUS_CFG, 8'h00);
	endtask : t_regs

	// all three gain ranges; the controller would pick the narrowest that fits
	task automatic t_bus(input logic [1:0] mode);
		for (int i = 0; i < 3; i++)
		begin
			cfg(REG_CORR_CTRL, {4'h0, 2'(2 - i), mode});
			px(10'd500, 10'h3f0);
			px(10'd100, 10'h0c8);
			px(10'd1023, 10'h001);
			px(10'd900, 10'h3ff);
			px(10'd10, 10'h2ff);
			drain();
		end
	endtask : t_bus

	task automatic t_full();
		bit took;
		logic [PIX_W-1:0] v, last;
		// range code 11 must act as the widest range
		cfg(REG_CORR_CTRL, 8'h0c);
		took = 1'b1;
		for (int i = 0; i < 24 && took; i++)
			send(10'(37 * i), 10'h010, took);
		check({9'h0, adc_ready}, 10'h000, "ready while full");
		check(10'(expq.size() >= FIFO_DEPTH), 10'h001, "words held");
		last = expq[$];
		drain();
		u_scan_ctrl_model.read_pixel(v);
		check(v, last, "empty read");
	endtask : t_full

	initial
	begin
		rst_n = 1'b0;
		adc_valid = 1'b0;
		adc_code = 10'h000;
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_regs();
		t_bus(2'h0);
		cfg(REG_FIXED_OFFSET, 8'h14);
		cfg(REG_FIXED_GAIN_A, 8'h40);
		cfg(REG_FIXED_GAIN_B, 8'hfe);
		t_bus(2'h1);
		t_bus(2'h2);
		t_bus(2'h3);
		cfg(REG_BUS_CFG, 8'h40);
		t_bus(2'h0);
		cfg(REG_BUS_CFG, 8'h00);
		t_full();
		report_and_stop();
	end
endmodule : pixel_rate_correction_path_bench
